// ===== bcc_pkg.sv
// Package of constants and types for the bus common control block
package bcc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] CMN_CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;

    ////////////////////////////////////////////////////////////////////////////
    // Common control field positions
    localparam int unsigned BIT_MAP_SEL = 12;
    localparam int unsigned BIT_RSV_ONE_HI = 4;
    localparam int unsigned BIT_BYTE_ORDER = 3;
    localparam int unsigned BIT_RSV_ONE_LO = 2;
    localparam int unsigned BIT_MEM_FLOAT = 1;
    localparam int unsigned BIT_CTL_FLOAT = 0;

    // Masks and values after reset
    localparam logic [31:0] CMN_ONES_MASK = 32'h0000_0014;
    localparam logic [31:0] CMN_WR_MASK = 32'h0000_1003;
    localparam logic [31:0] CMN_RO_FLAG_MASK = 32'h0000_0008;
    localparam logic [31:0] CMN_RESET_VAL = 32'h0000_0014;
    localparam logic RST_MAP_SEL = 1'h0;
    localparam logic RST_MEM_DRIVE = 1'h0;
    localparam logic RST_CTL_DRIVE = 1'h0;
    localparam logic RST_BYTE_ORDER = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Status field positions
    localparam int unsigned ST_CAPTURED = 0;
    localparam int unsigned ST_STANDBY = 1;
    localparam int unsigned ST_MEM_FLOATING = 2;
    localparam int unsigned ST_CTL_FLOATING = 3;
    localparam int unsigned ST_RSV_VIOL = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts
    localparam logic [1:0] CAPTURE_CYCLES = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [0:0] {
        BCC_IDLE = 1'b0,
        BCC_ACK = 1'b1
    } bcc_bus_st_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [BE_W-1:0] byteenable;
    } bcc_avs_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic waitrequest;
    } bcc_avs_rsp_t;

    typedef struct packed {
        logic meta;
        logic sync;
    } bcc_sync_t;

    typedef struct packed {
        logic [1:0] oe_n;
        logic standby;
    } bcc_float_t;

    typedef struct packed {
        bcc_bus_st_t bus_st;
        bcc_avs_rsp_t rsp;
        logic map_sel;
        logic mem_drive;
        logic ctl_drive;
        logic byte_order;
        logic captured;
        logic [1:0] cap_cnt;
        logic rsv_viol;
    } bcc_state_t;

endpackage

// ===== bcc_sync.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module bcc_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous level in
    input wire logic async_in,
    // Synchronised level out
    output logic sync_out
);

    bcc_pkg::bcc_sync_t st_r;
    bcc_pkg::bcc_sync_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = async_in;
        st_nxt.sync = st_r.meta;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.sync;

endmodule

// ===== bcc_pin_float.sv
// Standby output-enable generation for the two pin groups
`timescale 1ns/1ps
module bcc_pin_float (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Standby request and per-group drive selects
    input wire logic standby,
    input wire logic [1:0] drive_en,
    // Active-low pin enables and standby echo
    output logic [1:0] oe_n,
    output logic standby_seen
);

    bcc_pkg::bcc_float_t st_r;
    bcc_pkg::bcc_float_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.standby = standby;
        for (int i = 0; i < 2; i++) begin
            // Float only in standby with the group's drive select at zero
            st_nxt.oe_n[i] = standby & ~drive_en[i]; // [R6] [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign oe_n = st_r.oe_n;
    assign standby_seen = st_r.standby;

endmodule

// ===== bcc_top.sv
// Bus common control register with strap capture and standby pin control
//
// Behaviour
// [R1] After reset the byte-order strap pin is sampled once: low means big endian, high little.
// [R2] Bit 3 reads the captured strap level and is never written by software.
// [R3] Bit 12 selects the external address map, 0 the first and 1 the second, reset 0.
// [R4] Bits 31 to 13 and 11 to 5 read zero and software writes zero to them.
// [R5] Bits 4 and 2 read one and software writes one to them.
// [R6] Bit 1, reset 0, keeps the memory pin group driven in standby when 1, floating when 0.
// [R7] Bit 0, reset 0, keeps the clock and strobe pin group driven in standby when 1.
// [R8] Software makes no external access beyond area 0 until this register is configured.
// [R9] Writes leave the flag and reserved bits as they read; writable bits take the write.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
module bcc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire bcc_pkg::bcc_avs_req_t avs_req,
    output bcc_pkg::bcc_avs_rsp_t avs_rsp,
    // Strap and standby
    input wire logic byte_order_strap_pin,
    input wire logic standby_req,
    // Configuration to the bus state controller
    output logic map_select,
    output logic little_endian,
    output logic config_valid,
    // Standby pin enables, low while driving
    output logic memory_pins_oe_n,
    output logic control_pins_oe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    bcc_pkg::bcc_state_t st_r;
    bcc_pkg::bcc_state_t st_nxt;
    logic strap_sync;
    logic standby_seen;
    logic [1:0] float_oe_n;
    logic [1:0] drive_en;
    logic [31:0] cmn_rd;
    logic [31:0] status_rd;
    logic [31:0] lane_mask;
    logic [31:0] rsv_check;
    logic hit_cmn;
    logic hit_status;
    logic req_any;
    logic wr_done;

    ////////////////////////////////////////////////////////////////////////////
    // Strap synchroniser
    bcc_sync u_strap_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(byte_order_strap_pin),
        .sync_out(strap_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Standby pin enables
    assign drive_en = {st_r.mem_drive, st_r.ctl_drive};

    bcc_pin_float u_pin_float (
        .clk(clk),
        .rst_n(rst_n),
        .standby(standby_req),
        .drive_en(drive_en),
        .oe_n(float_oe_n),
        .standby_seen(standby_seen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign hit_cmn = (avs_req.address == bcc_pkg::CMN_CTRL_OFS);
    assign hit_status = (avs_req.address == bcc_pkg::STATUS_OFS);
    assign req_any = avs_req.read | avs_req.write;
    assign wr_done = (st_r.bus_st == bcc_pkg::BCC_ACK) & avs_req.write;

    ////////////////////////////////////////////////////////////////////////////
    // Read images
    always_comb begin
        cmn_rd = bcc_pkg::CMN_ONES_MASK; // [R4] [R5]
        cmn_rd[bcc_pkg::BIT_MAP_SEL] = st_r.map_sel; // [R3]
        cmn_rd[bcc_pkg::BIT_BYTE_ORDER] = st_r.byte_order; // [R2]
        cmn_rd[bcc_pkg::BIT_MEM_FLOAT] = st_r.mem_drive; // [R6]
        cmn_rd[bcc_pkg::BIT_CTL_FLOAT] = st_r.ctl_drive; // [R7]
    end

    always_comb begin
        status_rd = '0;
        status_rd[bcc_pkg::ST_CAPTURED] = st_r.captured;
        status_rd[bcc_pkg::ST_STANDBY] = standby_seen;
        status_rd[bcc_pkg::ST_MEM_FLOATING] = float_oe_n[1];
        status_rd[bcc_pkg::ST_CTL_FLOATING] = float_oe_n[0];
        status_rd[bcc_pkg::ST_RSV_VIOL] = st_r.rsv_viol;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reserved-bit write check on enabled lanes
    always_comb begin
        lane_mask = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
                     {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
        rsv_check = (avs_req.writedata ^ bcc_pkg::CMN_ONES_MASK) & lane_mask
                    & ~bcc_pkg::CMN_WR_MASK & ~bcc_pkg::CMN_RO_FLAG_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;

        // Strap capture once the synchroniser has filled
        if (!st_r.captured) begin
            if (st_r.cap_cnt == bcc_pkg::CAPTURE_CYCLES) begin
                st_nxt.byte_order = strap_sync; // [R1]
                st_nxt.captured = 1'b1; // [R1]
            end else begin
                st_nxt.cap_cnt = st_r.cap_cnt + 2'h1;
            end
        end

        // Bus handshake: one wait cycle, then a one-cycle answer
        unique case (st_r.bus_st)
            bcc_pkg::BCC_IDLE: begin
                st_nxt.rsp.waitrequest = 1'b1;
                if (req_any) begin
                    st_nxt.bus_st = bcc_pkg::BCC_ACK;
                    st_nxt.rsp.waitrequest = 1'b0;
                    if (avs_req.read) begin
                        if (hit_cmn) begin
                            st_nxt.rsp.readdata = cmn_rd;
                        end else if (hit_status) begin
                            st_nxt.rsp.readdata = status_rd;
                        end else begin
                            st_nxt.rsp.readdata = '0;
                        end
                    end
                end
            end
            bcc_pkg::BCC_ACK: begin
                st_nxt.bus_st = bcc_pkg::BCC_IDLE;
                st_nxt.rsp.waitrequest = 1'b1;
            end
        endcase

        // Register writes at the answering edge
        if (wr_done && hit_status) begin
            if (avs_req.byteenable[0] && avs_req.writedata[bcc_pkg::ST_RSV_VIOL]) begin
                st_nxt.rsv_viol = 1'b0;
            end
        end
        if (wr_done && hit_cmn) begin
            if (avs_req.byteenable[0]) begin
                st_nxt.mem_drive = avs_req.writedata[bcc_pkg::BIT_MEM_FLOAT]; // [R6] [R9]
                st_nxt.ctl_drive = avs_req.writedata[bcc_pkg::BIT_CTL_FLOAT]; // [R7] [R9]
            end
            if (avs_req.byteenable[1]) begin
                st_nxt.map_sel = avs_req.writedata[bcc_pkg::BIT_MAP_SEL]; // [R3] [R9]
            end
            // Flag a software write that breaks the fixed-bit pattern; set wins
            if (rsv_check != '0) begin
                st_nxt.rsv_viol = 1'b1; // [R4] [R5]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r.bus_st <= bcc_pkg::BCC_IDLE;
            st_r.rsp.readdata <= '0;
            st_r.rsp.waitrequest <= 1'b1;
            st_r.map_sel <= bcc_pkg::RST_MAP_SEL; // [R3]
            st_r.mem_drive <= bcc_pkg::RST_MEM_DRIVE; // [R6]
            st_r.ctl_drive <= bcc_pkg::RST_CTL_DRIVE; // [R7]
            st_r.byte_order <= bcc_pkg::RST_BYTE_ORDER;
            st_r.captured <= 1'b0;
            st_r.cap_cnt <= '0;
            st_r.rsv_viol <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign avs_rsp = st_r.rsp;
    assign map_select = st_r.map_sel;
    assign little_endian = st_r.byte_order;
    assign config_valid = st_r.captured;
    assign memory_pins_oe_n = float_oe_n[1];
    assign control_pins_oe_n = float_oe_n[0];

endmodule

// ===== bcc_top_props.sv
// Checker of the bus common control block ports
`timescale 1ns/1ps
module bcc_top_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire bcc_pkg::bcc_avs_req_t avs_req,
    input wire bcc_pkg::bcc_avs_rsp_t avs_rsp,
    // Strap and standby
    input wire logic byte_order_strap_pin,
    input wire logic standby_req,
    // Outputs
    input wire logic map_select,
    input wire logic little_endian,
    input wire logic config_valid,
    input wire logic memory_pins_oe_n,
    input wire logic control_pins_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the two drive bits
    logic ans;
    logic ctl_rd;
    logic ctl_wr;
    logic [1:0] drv_r;
    logic req_any;
    logic mem_exp;
    logic ctl_exp;
    assign ans = !avs_rsp.waitrequest && avs_req.address == bcc_pkg::CMN_CTRL_OFS;
    assign ctl_rd = ans && avs_req.read;
    assign ctl_wr = ans && avs_req.write && avs_req.byteenable[0];
    assign req_any = avs_req.read || avs_req.write;
    assign mem_exp = standby_req && !drv_r[1];
    assign ctl_exp = standby_req && !drv_r[0];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drv_r <= 2'h0;
        end else if (ctl_wr) begin
            drv_r <= avs_req.writedata[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_zero_bits: assert property (ctl_rd |-> (avs_rsp.readdata & 32'hFFFF_EFE0) == 32'h0)
        else $error("reserved zero bits read nonzero");
    a_one_bits: assert property (ctl_rd |-> avs_rsp.readdata[4] && avs_rsp.readdata[2])
        else $error("reserved one bits read zero");
    a_flag_read: assert property (ctl_rd && config_valid && $past(config_valid)
        |-> avs_rsp.readdata[3] == little_endian)
        else $error("byte order flag differs from capture");
    a_map_read: assert property (ctl_rd |-> avs_rsp.readdata[12] == map_select)
        else $error("map bit read differs from output");
    a_map_write: assert property (ans && avs_req.write && avs_req.byteenable[1]
        |=> map_select == $past(avs_req.writedata[12]))
        else $error("map select not updated by write");
    a_strap_take: assert property ($rose(config_valid)
        |-> little_endian == byte_order_strap_pin)
        else $error("strap level not captured");
    a_flag_hold: assert property (config_valid |=> config_valid && $stable(little_endian))
        else $error("captured byte order changed");
    a_mem_float: assert property (memory_pins_oe_n == $past(mem_exp))
        else $error("memory pin enable wrong");
    a_ctl_float: assert property (control_pins_oe_n == $past(ctl_exp))
        else $error("control pin enable wrong");
    a_req_answer: assert property (req_any && !$past(req_any)
        |-> avs_rsp.waitrequest ##1 !avs_rsp.waitrequest)
        else $error("request not answered in time");
    ////////////////////////////////////////////////////////////////////////////
    // Covers
    c_ctl_read: cover property (ctl_rd);
    c_little: cover property ($rose(config_valid) && byte_order_strap_pin);
    c_float: cover property (standby_req && memory_pins_oe_n && control_pins_oe_n);
endmodule
bind bcc_top bcc_top_props u_props (.clk(clk), .rst_n(rst_n), .avs_req(avs_req),
    .avs_rsp(avs_rsp), .byte_order_strap_pin(byte_order_strap_pin),
    .standby_req(standby_req), .map_select(map_select), .little_endian(little_endian),
    .config_valid(config_valid), .memory_pins_oe_n(memory_pins_oe_n),
    .control_pins_oe_n(control_pins_oe_n));

// ===== bcc_top_tb.sv
// Testbench of the bus common control block
`timescale 1ns/1ps
module bcc_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b0;
    logic stby = 1'b0;
    bcc_pkg::bcc_avs_req_t req = '0;
    bcc_pkg::bcc_avs_rsp_t rsp;
    logic map_sel;
    logic le;
    logic cfg_v;
    logic mem_oe_n;
    logic ctl_oe_n;
    logic s;
    logic [3:0] be;
    logic [31:0] rd;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] ctrl;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////////
    always #12.5 clk = ~clk;
    bcc_top u_dut (.clk(clk), .rst_n(rst_n), .avs_req(req), .avs_rsp(rsp),
        .byte_order_strap_pin(strap), .standby_req(stby), .map_select(map_sel),
        .little_endian(le), .config_valid(cfg_v), .memory_pins_oe_n(mem_oe_n),
        .control_pins_oe_n(ctl_oe_n));
    ////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] b);
        req.read <= !wr;
        req.write <= wr;
        req.address <= a;
        req.writedata <= wd;
        req.byteenable <= b;
        @(posedge clk);
        while (rsp.waitrequest !== 1'b0) @(posedge clk);
        rd = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rd = $urandom(32'hA153C078);
        d = $urandom();
        for (int k = 0; k < 2; k++) begin
            s = d[0] ^ k[0];
            rst_n <= 1'b0;
            strap <= s;
            stby <= 1'b0;
            ctrl = 32'h0;
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            repeat (6) @(posedge clk);
            chk({31'h0, cfg_v}, 32'h1);
            chk({31'h0, le}, {31'h0, s});
            chk({31'h0, map_sel}, 32'h0);
            bus(1'b0, bcc_pkg::CMN_CTRL_OFS, 32'h0, 4'hF);
            chk(rd, 32'h14 | {28'h0, s, 3'h0});
            bus(1'b0, 8'h10, 32'h0, 4'hF);
            chk(rd, 32'h0);
            $display("test reset done");
            for (int i = 0; i < 20; i++) begin
                d = $urandom();
                be = $urandom();
                m = bcc_pkg::CMN_WR_MASK | bcc_pkg::CMN_RO_FLAG_MASK;
                d = (d & m) | bcc_pkg::CMN_ONES_MASK;
                bus(1'b1, bcc_pkg::CMN_CTRL_OFS, d, be);
                m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & bcc_pkg::CMN_WR_MASK;
                ctrl = (ctrl & ~m) | (d & m);
                chk({31'h0, map_sel}, {31'h0, ctrl[12]});
                bus(1'b0, bcc_pkg::CMN_CTRL_OFS, 32'h0, 4'hF);
                chk(rd, 32'h14 | {28'h0, s, 3'h0} | ctrl);
            end
            bus(1'b0, bcc_pkg::STATUS_OFS, 32'h0, 4'hF);
            chk(rd, 32'h1);
            $display("test writes done");
            for (int b = 0; b < 4; b++) begin
                bus(1'b1, bcc_pkg::CMN_CTRL_OFS, 32'h14 | b, 4'hF);
                stby <= 1'b1;
                repeat (3) @(posedge clk);
                chk({30'h0, mem_oe_n, ctl_oe_n}, {30'h0, ~b[1:0]});
                stby <= 1'b0;
                repeat (3) @(posedge clk);
                chk({30'h0, mem_oe_n, ctl_oe_n}, 32'h0);
            end
            $display("test standby done");
        end
        end_of_test();
    end
endmodule
